// *** logic/llc_pkg.sv ***
package llc_pkg;

   // Lanes covered by this capture bank
   localparam int LLC_LANES = 3;
   localparam int LLC_AW = 12;
   localparam int LLC_DW = 8;

   // Register offsets
   localparam logic [11:0] ADDR_LINK_CTRL = 12'h300;
   localparam logic [11:0] ADDR_FORMAT_DENSITY_CTRLWORD = 12'h40a;
   localparam logic [11:0] ADDR_RESERVED_OCTET_ONE = 12'h40b;
   localparam logic [11:0] ADDR_RESERVED_OCTET_TWO = 12'h40c;
   localparam logic [11:0] ADDR_LANE0_RECEIVED_SUM = 12'h40d;
   localparam logic [11:0] ADDR_LANE0_COMPUTED_SUM = 12'h40e;
   localparam logic [11:0] ADDR_LANE1_IDENTIFIER = 12'h412;
   localparam logic [11:0] ADDR_LANE1_RECEIVED_SUM = 12'h415;
   localparam logic [11:0] ADDR_LANE1_COMPUTED_SUM = 12'h416;
   localparam logic [11:0] ADDR_LANE2_IDENTIFIER = 12'h41a;

   // Field positions
   localparam int SUM_METHOD_BIT = 6;
   localparam int DENSITY_BIT = 7;
   localparam int CTRL_WORDS_MSB = 4;
   localparam int LANE_IDENT_MSB = 4;

   // Reset values
   localparam logic [7:0] LINK_CTRL_RST = 8'h00;
   localparam logic [7:0] CAPTURE_RST = 8'h00;

   // Configuration octet positions within the alignment sequence
   localparam logic [3:0] OCT_FIRST = 4'h0;
   localparam logic [3:0] OCT_LANE_IDENT = 4'h2;
   localparam logic [3:0] OCT_FORMAT = 4'ha;
   localparam logic [3:0] OCT_RES_A = 4'hb;
   localparam logic [3:0] OCT_RES_B = 4'hc;
   localparam logic [3:0] OCT_SENT_SUM = 4'hd;

   typedef enum logic [1:0] {
      LLC_IDLE = 2'b01,
      LLC_COLLECT = 2'b10
   } llc_lane_state_t;

endpackage

// *** logic/llc_octet_sum.sv ***
`timescale 1ns/1ps
module llc_octet_sum
   import llc_pkg::*;
(
   // Octet in
   input wire logic [3:0] idx,
   input wire logic [7:0] octet,
   // Contributions
   output logic [7:0] field_sum,
   output logic [7:0] octet_sum
);
   wire [7:0] hi4 = {4'h0, octet[7:4]};
   wire [7:0] lo4 = {4'h0, octet[3:0]};
   wire [7:0] lo5 = {3'h0, octet[4:0]};
   wire [7:0] b7 = {7'h0, octet[7]};
   wire [7:0] b6 = {7'h0, octet[6]};
   wire [7:0] b5 = {7'h0, octet[5]};
   wire [7:0] top2 = {6'h0, octet[7:6]};
   wire [7:0] top3 = {5'h0, octet[7:5]};
   wire [7:0] sum_nib = hi4 + lo4;
   wire [7:0] sum_lid = b6 + b5 + lo5;
   wire [7:0] sum_b7 = b7 + lo5;
   wire [7:0] sum_cs = top2 + lo5;
   wire [7:0] sum_t3 = top3 + lo5;
   // Whole-octet fields: identifiers and the minus-one counts
   wire whole = (idx == 4'h0) || (idx == 4'h4) || (idx == 4'h6);
   // Reserved octets and the sent sum never enter the checksum
   wire summed = (idx <= OCT_FORMAT);

   assign field_sum = whole ? octet :
                      (idx == 4'h1) ? sum_nib :
                      (idx == OCT_LANE_IDENT) ? sum_lid :
                      (idx == 4'h3 || idx == OCT_FORMAT) ? sum_b7 :
                      (idx == 4'h5) ? lo5 :
                      (idx == 4'h7) ? sum_cs :
                      (idx == 4'h8 || idx == 4'h9) ? sum_t3 : 8'h00;
   assign octet_sum = summed ? octet : 8'h00;
endmodule

// *** logic/llc_lane_collect.sv ***
`timescale 1ns/1ps
module llc_lane_collect
   import llc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Accepted octet and its place in the sequence
   input wire logic take,
   input wire logic [3:0] cur_idx,
   input wire logic [7:0] cfg_octet,
   // Fields of the sequence in flight
   output logic [7:0] lane_ident,
   output logic [7:0] fmt_octet,
   output logic [7:0] res_a,
   output logic [7:0] res_b,
   output logic [7:0] sent_sum
);
   // Partial sequences land only here; the owner commits a whole one
   logic [7:0] lid_q, fmt_q, ra_q, rb_q, chk_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         lid_q <= CAPTURE_RST;
         fmt_q <= CAPTURE_RST;
         ra_q <= CAPTURE_RST;
         rb_q <= CAPTURE_RST;
         chk_q <= CAPTURE_RST;
      end else if (take) begin
         if (cur_idx == OCT_LANE_IDENT) lid_q <= cfg_octet;
         if (cur_idx == OCT_FORMAT) fmt_q <= cfg_octet;
         if (cur_idx == OCT_RES_A) ra_q <= cfg_octet;
         if (cur_idx == OCT_RES_B) rb_q <= cfg_octet;
         if (cur_idx == OCT_SENT_SUM) chk_q <= cfg_octet;
      end
   end

   assign lane_ident = lid_q;
   assign fmt_octet = fmt_q;
   assign res_a = ra_q;
   assign res_b = rb_q;
   assign sent_sum = chk_q;
endmodule

// *** logic/llc_lane_cfg_capture.sv ***
`timescale 1ns/1ps
module llc_lane_cfg_capture
   import llc_pkg::*;
#(
   parameter int LANES = LLC_LANES
) (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET,
   // Register port
   input wire logic [LLC_AW-1:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [LLC_DW-1:0] REG_WDATA,
   output logic [LLC_DW-1:0] REG_RDATA,
   output logic REG_RVALID,
   // Configuration octets from the lane deframers
   input wire logic [LANES-1:0] LANE_CFG_VALID,
   input wire logic [LANES-1:0] LANE_CFG_START,
   input wire logic [8*LANES-1:0] LANE_CFG_OCTET,
   // Status
   output logic SUM_METHOD_SELECT,
   output logic [LANES-1:0] CAPTURE_SEEN,
   output logic [LANES-1:0] SUM_MISMATCH
);
   // Per-lane collector results
   logic [LANES-1:0] commit;
   logic [7:0] c_lid [LANES];
   logic [7:0] c_fmt [LANES];
   logic [7:0] c_ra [LANES];
   logic [7:0] c_rb [LANES];
   logic [7:0] c_sent [LANES];
   logic [7:0] c_field [LANES];
   logic [7:0] c_octet [LANES];

   // Captured per-lane state
   logic [7:0] sent_q [LANES];
   logic [7:0] field_q [LANES];
   logic [7:0] octsum_q [LANES];
   logic [4:0] ident_q [LANES];
   logic [LANES-1:0] seen_q;

   // Lane 0 shared link parameters
   logic density_flag_seen_q, density_flag_seen_d;
   logic [4:0] ctrl_words_per_frame_seen_q, ctrl_words_per_frame_seen_d;
   logic [7:0] reserved_octet_a_q, reserved_octet_a_d;
   logic [7:0] reserved_octet_b_q, reserved_octet_b_d;

   // Link control register
   logic [7:0] link_ctrl_q, link_ctrl_d;

   // Read path
   logic [7:0] rdata_q, rdata_d;
   logic rvalid_q;

   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : gen_lane
         // Octet intake for this lane
         llc_lane_state_t state_q, state_d;
         logic [3:0] idx_q, idx_d;
         logic commit_q;
         logic [7:0] fsum_q, osum_q;
         logic [7:0] f_add, o_add;

         wire valid_in = LANE_CFG_VALID[g];
         wire start_in = LANE_CFG_START[g];
         wire [7:0] octet_in = LANE_CFG_OCTET[8*g +: 8];
         wire take_first = valid_in && start_in;
         wire take_next = valid_in && !start_in && (state_q == LLC_COLLECT);
         wire take = take_first || take_next;
         wire [3:0] cur_idx = take_first ? OCT_FIRST : idx_q;
         wire last = take && (cur_idx == OCT_SENT_SUM);

         llc_octet_sum u_sum (
            .idx(cur_idx),
            .octet(octet_in),
            .field_sum(f_add),
            .octet_sum(o_add)
         );

         llc_lane_collect u_collect (
            .clk(CLK_SYS),
            .rst(RESET),
            .take(take),
            .cur_idx(cur_idx),
            .cfg_octet(octet_in),
            .lane_ident(c_lid[g]),
            .fmt_octet(c_fmt[g]),
            .res_a(c_ra[g]),
            .res_b(c_rb[g]),
            .sent_sum(c_sent[g])
         );

         // A start octet always restarts, even inside an open sequence
         always_comb begin
            state_d = state_q;
            idx_d = idx_q;
            unique case (state_q)
               LLC_IDLE: begin
                  if (take_first) begin
                     state_d = LLC_COLLECT;
                     idx_d = 4'h1;
                  end
               end
               LLC_COLLECT: begin
                  if (last) begin
                     state_d = LLC_IDLE;
                  end else if (take) begin
                     idx_d = cur_idx + 4'h1;
                  end
               end
            endcase
         end

         always_ff @(posedge CLK_SYS) begin
            if (RESET) begin
               state_q <= LLC_IDLE;
               idx_q <= OCT_FIRST;
            end else begin
               state_q <= state_d;
               idx_q <= idx_d;
            end
         end

         // Commit one edge after the closing octet, once its latch has settled
         always_ff @(posedge CLK_SYS) begin
            if (RESET) begin
               commit_q <= 1'b0;
            end else begin
               commit_q <= last;
            end
         end

         // Both totals run so the method bit can change without new data
         always_ff @(posedge CLK_SYS) begin
            if (RESET) begin
               fsum_q <= CAPTURE_RST;
               osum_q <= CAPTURE_RST;
            end else if (take) begin
               fsum_q <= take_first ? f_add : fsum_q + f_add;
               osum_q <= take_first ? o_add : osum_q + o_add;
            end
         end

         assign commit[g] = commit_q;
         assign c_field[g] = fsum_q;
         assign c_octet[g] = osum_q;

         // Values move only when a whole sequence has arrived
         always_ff @(posedge CLK_SYS) begin
            if (RESET) begin
               sent_q[g] <= CAPTURE_RST;
               field_q[g] <= CAPTURE_RST;
               octsum_q[g] <= CAPTURE_RST;
               ident_q[g] <= CAPTURE_RST[4:0];
            end else if (commit[g]) begin
               sent_q[g] <= c_sent[g];
               field_q[g] <= c_field[g];
               octsum_q[g] <= c_octet[g];
               ident_q[g] <= c_lid[g][LANE_IDENT_MSB:0];
            end
         end

         // Stays up until reset once any sequence has landed
         always_ff @(posedge CLK_SYS) begin
            if (RESET) begin
               seen_q[g] <= 1'b0;
            end else if (commit[g]) begin
               seen_q[g] <= 1'b1;
            end
         end

         // Method bit chooses between the two running totals
         wire [7:0] calc = link_ctrl_q[SUM_METHOD_BIT] ? octsum_q[g] : field_q[g];

         // Disagreement shows a setup or line fault
         assign SUM_MISMATCH[g] = seen_q[g] && (calc != sent_q[g]);
      end
   endgenerate

   // Sum shown for a lane under the current method
   wire [7:0] calc0 = link_ctrl_q[SUM_METHOD_BIT] ? octsum_q[0] : field_q[0];
   wire [7:0] calc1 = link_ctrl_q[SUM_METHOD_BIT] ? octsum_q[1] : field_q[1];

   // Shared parameters are taken from lane 0 alone
   wire lane0_commit = commit[0];
   // Transmitters other than zero control words are not checked here
   // because the frame path does not decode them; the count is only shown.
   wire [4:0] cf_in = c_fmt[0][CTRL_WORDS_MSB:0];

   assign density_flag_seen_d = lane0_commit ? c_fmt[0][DENSITY_BIT] :
                                density_flag_seen_q;
   assign ctrl_words_per_frame_seen_d = lane0_commit ? cf_in :
                                        ctrl_words_per_frame_seen_q;
   assign reserved_octet_a_d = lane0_commit ? c_ra[0] : reserved_octet_a_q;
   assign reserved_octet_b_d = lane0_commit ? c_rb[0] : reserved_octet_b_q;

   // Format fields
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         density_flag_seen_q <= 1'b0;
         ctrl_words_per_frame_seen_q <= CAPTURE_RST[4:0];
      end else begin
         density_flag_seen_q <= density_flag_seen_d;
         ctrl_words_per_frame_seen_q <= ctrl_words_per_frame_seen_d;
      end
   end

   // Reserved octets are kept verbatim
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         reserved_octet_a_q <= CAPTURE_RST;
         reserved_octet_b_q <= CAPTURE_RST;
      end else begin
         reserved_octet_a_q <= reserved_octet_a_d;
         reserved_octet_b_q <= reserved_octet_b_d;
      end
   end

   // Address decode
   wire hit_ctrl = (REG_ADDR == ADDR_LINK_CTRL);
   wire hit_fmt = (REG_ADDR == ADDR_FORMAT_DENSITY_CTRLWORD);
   wire hit_ra = (REG_ADDR == ADDR_RESERVED_OCTET_ONE);
   wire hit_rb = (REG_ADDR == ADDR_RESERVED_OCTET_TWO);
   wire hit_s0 = (REG_ADDR == ADDR_LANE0_RECEIVED_SUM);
   wire hit_c0 = (REG_ADDR == ADDR_LANE0_COMPUTED_SUM);
   wire hit_id1 = (REG_ADDR == ADDR_LANE1_IDENTIFIER);
   wire hit_s1 = (REG_ADDR == ADDR_LANE1_RECEIVED_SUM);
   wire hit_c1 = (REG_ADDR == ADDR_LANE1_COMPUTED_SUM);
   wire hit_id2 = (REG_ADDR == ADDR_LANE2_IDENTIFIER);

   // Only the control register takes writes; capture registers drop them
   wire ctrl_wr = REG_WR && hit_ctrl;
   assign link_ctrl_d = ctrl_wr ? REG_WDATA : link_ctrl_q;

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         link_ctrl_q <= LINK_CTRL_RST;
      end else begin
         link_ctrl_q <= link_ctrl_d;
      end
   end

   // Register images; reserved bits read as zero
   wire [7:0] img_ctrl = link_ctrl_q;
   wire [7:0] img_fmt = {density_flag_seen_q, 2'b00, ctrl_words_per_frame_seen_q};
   wire [7:0] img_ra = reserved_octet_a_q;
   wire [7:0] img_rb = reserved_octet_b_q;
   wire [7:0] img_s0 = sent_q[0];
   wire [7:0] img_c0 = calc0;
   wire [7:0] img_id1 = {3'b000, ident_q[1]};
   wire [7:0] img_s1 = sent_q[1];
   wire [7:0] img_c1 = calc1;
   wire [7:0] img_id2 = {3'b000, ident_q[2]};

   // One-hot select; unmapped offsets read zero
   wire [7:0] read_mux = ({8{hit_ctrl}} & img_ctrl) |
                         ({8{hit_fmt}} & img_fmt) |
                         ({8{hit_ra}} & img_ra) |
                         ({8{hit_rb}} & img_rb) |
                         ({8{hit_s0}} & img_s0) |
                         ({8{hit_c0}} & img_c0) |
                         ({8{hit_id1}} & img_id1) |
                         ({8{hit_s1}} & img_s1) |
                         ({8{hit_c1}} & img_c1) |
                         ({8{hit_id2}} & img_id2);

   // Data held after a read so slow readers need not sample at once
   assign rdata_d = REG_RD ? read_mux : rdata_q;

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Answer strobe lasts exactly one cycle per read
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= REG_RD;
      end
   end

   assign REG_RDATA = rdata_q;
   assign REG_RVALID = rvalid_q;
   assign SUM_METHOD_SELECT = link_ctrl_q[SUM_METHOD_BIT];
   assign CAPTURE_SEEN = seen_q;

endmodule

// *** sim/llc_lane_cfg_capture_properties.sv ***
`timescale 1ns/1ps
module llc_cfg_capture_props
   import llc_pkg::*;
#(
   parameter int LANES = LLC_LANES
) (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET,
   // Register port
   input wire logic [LLC_AW-1:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [LLC_DW-1:0] REG_WDATA,
   input wire logic [LLC_DW-1:0] REG_RDATA,
   input wire logic REG_RVALID,
   // Lane octets
   input wire logic [LANES-1:0] LANE_CFG_VALID,
   input wire logic [LANES-1:0] LANE_CFG_START,
   input wire logic [8*LANES-1:0] LANE_CFG_OCTET,
   // Status
   input wire logic SUM_METHOD_SELECT,
   input wire logic [LANES-1:0] CAPTURE_SEEN,
   input wire logic [LANES-1:0] SUM_MISMATCH
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   sequence s_ctrl_wr;
      REG_WR && REG_ADDR == ADDR_LINK_CTRL;
   endsequence
   sequence s_ctrl_rd;
      REG_RD && REG_ADDR == ADDR_LINK_CTRL;
   endsequence
   // Capture lands two edges after the closing octet
   property p_capture(int g);
      $rose(CAPTURE_SEEN[g]) |-> $past(LANE_CFG_VALID[g] && !LANE_CFG_START[g], 2);
   endproperty
   a_read_answer: assert property (REG_RD |=> REG_RVALID)
      else $error("read not answered next cycle");
   a_answer_cause: assert property (REG_RVALID |-> $past(REG_RD))
      else $error("read valid without a read");
   a_rdata_holds: assert property (!REG_RVALID && !$past(RESET) |-> $stable(REG_RDATA))
      else $error("read data moved without a read");
   a_method_write: assert property (s_ctrl_wr |=> SUM_METHOD_SELECT == $past(REG_WDATA[6]))
      else $error("method bit not taken from write");
   a_method_holds: assert property (!(REG_WR && REG_ADDR == ADDR_LINK_CTRL)
      |=> $stable(SUM_METHOD_SELECT))
      else $error("method bit moved without write");
   a_ctrl_readback: assert property (s_ctrl_wr ##1 !REG_WR ##1 s_ctrl_rd
      |=> REG_RDATA == $past(REG_WDATA, 3))
      else $error("control register read back wrong");
   a_seen_sticks: assert property (1'b1 |=> (CAPTURE_SEEN & $past(CAPTURE_SEEN))
      == $past(CAPTURE_SEEN))
      else $error("capture seen dropped");
   a_lane0_capture: assert property (p_capture(0))
      else $error("lane 0 capture without closing octet");
   a_lane1_capture: assert property (p_capture(1))
      else $error("lane 1 capture without closing octet");
   a_mismatch_seen: assert property ((SUM_MISMATCH & ~CAPTURE_SEEN) == '0)
      else $error("mismatch flagged before capture");
endmodule

bind llc_lane_cfg_capture llc_cfg_capture_props #(.LANES(LANES)) u_props (
   .CLK_SYS(CLK_SYS), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
   .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
   .REG_RVALID(REG_RVALID), .LANE_CFG_VALID(LANE_CFG_VALID),
   .LANE_CFG_START(LANE_CFG_START), .LANE_CFG_OCTET(LANE_CFG_OCTET),
   .SUM_METHOD_SELECT(SUM_METHOD_SELECT), .CAPTURE_SEEN(CAPTURE_SEEN),
   .SUM_MISMATCH(SUM_MISMATCH));

// *** sim/llc_link_tx_model.sv ***
`timescale 1ns/1ps
module llc_link_tx_model
   import llc_pkg::*;
(
   // Clock shared with the receiver
   input wire logic clk,
   // Octet lanes
   output logic [LLC_LANES-1:0] valid,
   output logic [LLC_LANES-1:0] start,
   output logic [8*LLC_LANES-1:0] octet
);
   initial begin
      valid = '0;
      start = '0;
      octet = '0;
   end
   // Sum over octets 0..10, by field or by whole octet
   function automatic logic [7:0] fsum(input logic [7:0] f[13], input bit whole);
      logic [7:0] s;
      logic [7:0] o;
      s = 8'h00;
      for (int i = 0; i < 11; i++) begin
         o = f[i];
         if (whole) s += o;
         else case (i)
            0, 4, 6: s += o;
            1: s += o[7:4] + o[3:0];
            2: s += o[6] + o[5] + o[4:0];
            3, 10: s += o[7] + o[4:0];
            5: s += o[4:0];
            7: s += o[7:6] + o[4:0];
            default: s += o[7:5] + o[4:0];
         endcase
      end
      return s;
   endfunction
   // Sends the first n octets; a short n leaves the sequence open
   task automatic send(input int g, input logic [7:0] f[13], input bit whole,
      input int n, input int gap);
      logic [7:0] b;
      f[10][4:0] = 5'h00;
      for (int i = 0; i < n; i++) begin
         if (i == 13) b = fsum(f, whole);
         else b = f[i];
         @(negedge clk);
         valid[g] = 1'b1;
         start[g] = (i == 0);
         octet[8*g +: 8] = b;
         repeat (gap) begin
            @(negedge clk);
            valid[g] = 1'b0;
            octet[8*g +: 8] = ~b;
         end
      end
      // Released line shows the inverse, not a stale octet
      @(negedge clk);
      valid[g] = 1'b0;
      start[g] = 1'b0;
      octet[8*g +: 8] = ~b;
   endtask
endmodule

// *** sim/lane_link_config_capture_bench.sv ***
`timescale 1ns/1ps
module lane_link_config_capture_bench
   import llc_pkg::*;
;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [11:0] reg_addr = 12'h000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   logic [2:0] cfg_valid;
   logic [2:0] cfg_start;
   logic [23:0] cfg_octet;
   logic sum_sel;
   logic [2:0] seen;
   logic [2:0] mism;
   int fail_count = 0;
   int comparisons = 0;
   logic [7:0] fa[13];
   logic [7:0] fb[13];
   logic [7:0] fc[13];

   always #12.5 clk_sys = ~clk_sys;

   llc_lane_cfg_capture u_dut (.CLK_SYS(clk_sys), .RESET(reset), .REG_ADDR(reg_addr),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
      .REG_RVALID(reg_rvalid), .LANE_CFG_VALID(cfg_valid), .LANE_CFG_START(cfg_start),
      .LANE_CFG_OCTET(cfg_octet), .SUM_METHOD_SELECT(sum_sel), .CAPTURE_SEEN(seen),
      .SUM_MISMATCH(mism));
   llc_link_tx_model u_tx (.clk(clk_sys), .valid(cfg_valid), .start(cfg_start),
      .octet(cfg_octet));

   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
      @(negedge clk_sys);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      chk("read valid", {7'h00, reg_rvalid}, 8'h01);
      chk($sformatf("reg %h", a), reg_rdata, exp);
   endtask

   task automatic t_reset();
      logic [11:0] al[10] = '{12'h300, 12'h40a, 12'h40b, 12'h40c, 12'h40d, 12'h40e,
         12'h412, 12'h415, 12'h416, 12'h41a};
      foreach (al[i]) rchk(al[i], 8'h00);
      chk("status", {1'b0, sum_sel, seen, mism}, 8'h00);
      $display("Test reset done");
   endtask
   task automatic t_lanes();
      u_tx.send(0, fa, 1'b0, 14, 0);
      u_tx.send(1, fb, 1'b0, 14, 1);
      u_tx.send(2, fc, 1'b0, 14, 0);
      repeat (2) @(negedge clk_sys);
      rchk(12'h40a, fa[10] & 8'h9f);
      rchk(12'h40b, fa[11]);
      rchk(12'h40c, fa[12]);
      rchk(12'h40d, u_tx.fsum(fa, 1'b0));
      rchk(12'h40e, u_tx.fsum(fa, 1'b0));
      rchk(12'h412, fb[2] & 8'h1f);
      rchk(12'h415, u_tx.fsum(fb, 1'b0));
      rchk(12'h416, u_tx.fsum(fb, 1'b0));
      rchk(12'h41a, fc[2] & 8'h1f);
      chk("seen", {5'h00, seen}, 8'h07);
      chk("mismatch", {5'h00, mism}, 8'h00);
      $display("Test lanes done");
   endtask
   task automatic t_method();
      wr(12'h300, 8'h40);
      rchk(12'h300, 8'h40);
      chk("method", {7'h00, sum_sel}, 8'h01);
      rchk(12'h40e, u_tx.fsum(fa, 1'b1));
      rchk(12'h416, u_tx.fsum(fb, 1'b1));
      chk("mismatch", {5'h00, mism}, 8'h07);
      u_tx.send(0, fa, 1'b1, 14, 0);
      repeat (2) @(negedge clk_sys);
      rchk(12'h40d, u_tx.fsum(fa, 1'b1));
      chk("mismatch", {5'h00, mism}, 8'h06);
      $display("Test method done");
   endtask
   task automatic t_refuse();
      wr(12'h40d, 8'hff);
      wr(12'h40a, 8'h1f);
      rchk(12'h40d, u_tx.fsum(fa, 1'b1));
      rchk(12'h40a, fa[10] & 8'h9f);
      rchk(12'h7ff, 8'h00);
      // Checksum octet withheld, so nothing may land
      u_tx.send(0, fb, 1'b1, 13, 0);
      repeat (3) @(negedge clk_sys);
      rchk(12'h40b, fa[11]);
      u_tx.send(0, fb, 1'b1, 14, 0);
      repeat (2) @(negedge clk_sys);
      rchk(12'h40b, fb[11]);
      rchk(12'h40a, 8'h00);
      $display("Test refuse done");
   endtask

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      fa = '{8'h5a, 8'h23, 8'h61, 8'h83, 8'h01, 8'h1f, 8'h03, 8'h4f, 8'h2f, 8'h20,
         8'h80, 8'h3c, 8'hc3};
      fb = fa;
      fb[2] = 8'h6b;
      fb[10] = 8'h00;
      fb[11] = 8'h11;
      fb[12] = 8'h22;
      fc = fa;
      fc[2] = 8'h7e;
      repeat (3) @(negedge clk_sys);
      reset = 1'b0;
      t_reset();
      t_lanes();
      t_method();
      t_refuse();
      results();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk_sys);
      fail_count++;
      results();
   end
endmodule
